// ### core/iadh_pkg.sv
// Purpose: Shared constants and types for the I2C slave acknowledge and DMA request block
// Assumes: 32-bit register words at byte offsets, 8-bit I2C data bytes
// Notes:   Reserved register bits read as zero
// Contract
// (R1) Forced data-refuse bit set: every received data byte gets NACK, transfer aborts.
// (R2) Forced refuse acts only in slave receiver role; otherwise no effect on acknowledge.
// (R3) A byte refused by the forced refuse bit never enters the receive FIFO.
// (R4) Forced refuse bit clear: bytes acknowledged by the normal slave receiver decision.
// (R5) Receive DMA requests only while receive enable, bit 0 of DMA control, is set.
// (R6) Transmit DMA requests only while transmit enable, bit 1 of DMA control, is set.
// (R7) DMA controller must move 16-bit or 32-bit items only.
// (R8) Transmit request while transmit FIFO count is at or below 3-bit watermark.
// (R9) Receive request while receive FIFO count exceeds 3-bit watermark.
// (R10) 9-bit SDA setup count resets to 0x64; software never programs below 2.
// (R11) General Call address answered ACK when general-call bit is 1, NACK when 0.
// (R12) General-call acknowledge bit reads 1 after reset.
// (R13) DMA request drops once level condition fails or enable clears.
// (R14) SDA setup counted in reference clock periods before clock line release.
package iadh_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_SLAVE_DATA_REFUSE = 8'h84;
  localparam logic [7:0] OFS_DMA_REQ_ENABLE    = 8'h88;
  localparam logic [7:0] OFS_TX_DMA_WATERMARK  = 8'h8c;
  localparam logic [7:0] OFS_RX_DMA_WATERMARK  = 8'h90;
  localparam logic [7:0] OFS_SDA_SETUP_DELAY   = 8'h94;
  localparam logic [7:0] OFS_GC_ACK_CTRL       = 8'h98;

  // Field positions and widths
  localparam int unsigned BIT_REFUSE_NACK = 0;
  localparam int unsigned BIT_RX_DMA_EN   = 0;
  localparam int unsigned BIT_TX_DMA_EN   = 1;
  localparam int unsigned BIT_GC_ACK      = 0;
  localparam int unsigned WM_W            = 3;
  localparam int unsigned DLY_W           = 9;

  // Reset values and minimum SDA setup delay
  localparam logic             RST_REFUSE_NACK = 1'b0;
  localparam logic [1:0]       RST_DMA_ENABLE  = 2'h0;
  localparam logic [WM_W-1:0]  RST_WATERMARK   = 3'h0;
  localparam logic [DLY_W-1:0] RST_SDA_DELAY   = 9'h064;
  localparam logic             RST_GC_ACK      = 1'b1;
  localparam logic [DLY_W-1:0] MIN_SDA_DELAY   = 9'h002;

  // FIFO geometry
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned LVL_W      = 6;

  // One byte handed over by the protocol engine with its context
  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic              is_addr;
    logic              is_gc;
    logic              slave_rx;
    logic              normal_ack;
  } iadh_rx_byte_s;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } iadh_reg_req_s;

  typedef enum logic [1:0] {
    SU_IDLE,
    SU_COUNT
  } iadh_setup_e;

endpackage

// ### core/iadh_top.sv
// Purpose: Slave acknowledge policy, SDA setup timing and DMA requests of an I2C controller
// Assumes: Protocol engine and transmit FIFO sit outside; reference clock is a sampled pin
// Notes:   Receive bytes pass a 32-entry byte FIFO drained by the DMA side
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns

module iadh_fifo
  import iadh_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned CNT_W = 6
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [CNT_W-1:0] level
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  // Honest full and empty come straight from the level
  assign in_ready  = (level != CNT_W'(DEPTH));
  assign out_valid = (level != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // Storage has no reset, only pointers and level do
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap naturally when depth is a power of two
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + AW'(1);
      end
    end
  end

  // Occupancy count
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      level <= '0;
    end
    else if (push && !pop)
    begin
      level <= level + CNT_W'(1);
    end
    else if (pop && !push)
    begin
      level <= level - CNT_W'(1);
    end
  end

endmodule

module iadh_top
  import iadh_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire iadh_reg_req_s       reg_req,
  output logic          [31:0]     reg_rdata,
  input  wire logic                i2c_reference_clock,
  input  wire iadh_rx_byte_s       rx_byte,
  input  wire logic                rx_byte_valid,
  output logic                     rx_byte_ready,
  output logic                     ack_valid,
  output logic                     ack,
  input  wire logic                setup_start,
  output logic                     sda_hold,
  output logic                     scl_release,
  input  wire logic     [LVL_W-1:0] tx_fifo_level,
  output logic                     tx_dma_req,
  output logic                     rx_dma_req,
  output logic    [BYTE_W-1:0]     rx_dma_data,
  output logic                     rx_dma_valid,
  input  wire logic                rx_dma_ready
);

  logic                 refuse_nack;
  logic [1:0]           dma_enable;
  logic [WM_W-1:0]      tx_wm;
  logic [WM_W-1:0]      rx_wm;
  logic [DLY_W-1:0]     sda_delay;
  logic                 gc_ack;
  logic                 byte_taken;
  logic                 forced_refuse;
  logic                 next_ack;
  logic                 fifo_push;
  logic [LVL_W-1:0]     rx_level;
  logic                 ref_s1;
  logic                 ref_s2;
  logic                 ref_s3;
  logic                 ref_rise;
  iadh_setup_e          su_state;
  logic [DLY_W-1:0]     su_cnt;

  // Register address match, shared by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Software register writes; reserved bits are dropped
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      refuse_nack <= RST_REFUSE_NACK;
      dma_enable  <= RST_DMA_ENABLE;
      tx_wm       <= RST_WATERMARK;
      rx_wm       <= RST_WATERMARK;
      sda_delay   <= RST_SDA_DELAY;   // [R10]
      gc_ack      <= RST_GC_ACK;      // [R12]
    end
    else if (reg_req.wr)
    begin
      if (hit(reg_req.addr, OFS_SLAVE_DATA_REFUSE))
      begin
        refuse_nack <= reg_req.wdata[BIT_REFUSE_NACK];
      end
      if (hit(reg_req.addr, OFS_DMA_REQ_ENABLE))
      begin
        dma_enable <= reg_req.wdata[1:0];
      end
      if (hit(reg_req.addr, OFS_TX_DMA_WATERMARK))
      begin
        tx_wm <= reg_req.wdata[WM_W-1:0];
      end
      if (hit(reg_req.addr, OFS_RX_DMA_WATERMARK))
      begin
        rx_wm <= reg_req.wdata[WM_W-1:0];
      end
      if (hit(reg_req.addr, OFS_SDA_SETUP_DELAY))
      begin
        sda_delay <= reg_req.wdata[DLY_W-1:0]; // Values below 2 are software's fault [R10]
      end
      if (hit(reg_req.addr, OFS_GC_ACK_CTRL))
      begin
        gc_ack <= reg_req.wdata[BIT_GC_ACK];
      end
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_req.rd)
    begin
      unique case (1'b1)
        hit(reg_req.addr, OFS_SLAVE_DATA_REFUSE): reg_rdata <= {31'h0, refuse_nack};
        hit(reg_req.addr, OFS_DMA_REQ_ENABLE):    reg_rdata <= {30'h0, dma_enable};
        hit(reg_req.addr, OFS_TX_DMA_WATERMARK):  reg_rdata <= {29'h0, tx_wm};
        hit(reg_req.addr, OFS_RX_DMA_WATERMARK):  reg_rdata <= {29'h0, rx_wm};
        hit(reg_req.addr, OFS_SDA_SETUP_DELAY):   reg_rdata <= {23'h0, sda_delay};
        hit(reg_req.addr, OFS_GC_ACK_CTRL):       reg_rdata <= {31'h0, gc_ack};
        default:                                  reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Engine waits while the receive FIFO is full, so no byte is ever dropped silently
  assign byte_taken    = rx_byte_valid && rx_byte_ready;
  assign forced_refuse = refuse_nack && rx_byte.slave_rx && !rx_byte.is_addr; // [R1] [R2]

  // Acknowledge decision for the byte just taken
  always_comb
  begin
    if (rx_byte.is_addr && rx_byte.is_gc)
    begin
      next_ack = gc_ack;                 // [R11]
    end
    else if (forced_refuse)
    begin
      next_ack = 1'b0;                   // [R1]
    end
    else
    begin
      next_ack = rx_byte.normal_ack;     // [R4]
    end
  end

  // Only acknowledged data bytes reach the FIFO
  assign fifo_push = byte_taken && !rx_byte.is_addr && next_ack; // [R3]

  // Answer to the engine, one cycle after the byte is taken
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack_valid <= 1'b0;
      ack       <= 1'b0;
    end
    else
    begin
      ack_valid <= byte_taken;
      if (byte_taken)
      begin
        ack <= next_ack;
      end
    end
  end

  iadh_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH),
    .CNT_W (LVL_W)
  ) u_rx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (rx_byte.data),
    .in_valid  (fifo_push),
    .in_ready  (rx_byte_ready),
    .out_data  (rx_dma_data),
    .out_valid (rx_dma_valid),
    .out_ready (rx_dma_ready),
    .level     (rx_level)
  );

  // Requests are levels recomputed every cycle, so they drop one cycle after the cause
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
    end
    else
    begin
      tx_dma_req <= dma_enable[BIT_TX_DMA_EN] && tx_fifo_level <= LVL_W'(tx_wm); // [R6] [R8] [R13]
      rx_dma_req <= dma_enable[BIT_RX_DMA_EN] && rx_level > LVL_W'(rx_wm);       // [R5] [R9] [R13]
    end
  end

  // Reference clock is a foreign pin: two flops, then a third for the edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
    end
    else
    begin
      ref_s1 <= i2c_reference_clock;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
    end
  end

  assign ref_rise = ref_s2 && !ref_s3;

  // SDA setup: hold data for the programmed number of reference periods
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      su_state    <= SU_IDLE;
      su_cnt      <= '0;
      scl_release <= 1'b0;
    end
    else
    begin
      scl_release <= 1'b0;
      unique case (su_state)
        SU_IDLE:
        begin
          if (setup_start)
          begin
            su_cnt   <= sda_delay;
            su_state <= SU_COUNT;
          end
        end
        SU_COUNT:
        begin
          if (ref_rise)
          begin
            if (su_cnt <= DLY_W'(1))
            begin
              scl_release <= 1'b1;      // [R14]
              su_state    <= SU_IDLE;
            end
            else
            begin
              su_cnt <= su_cnt - DLY_W'(1); // [R14]
            end
          end
        end
      endcase
    end
  end

  assign sda_hold = (su_state == SU_COUNT);

  // Helper for checks: reference edges seen during one setup window
  logic [DLY_W-1:0] chk_edges;
  logic [DLY_W-1:0] chk_load;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      chk_edges <= '0;
      chk_load  <= '0;
    end
    else if (su_state == SU_IDLE && setup_start)
    begin
      chk_edges <= '0;
      chk_load  <= sda_delay;
    end
    else if (su_state == SU_COUNT && ref_rise)
    begin
      chk_edges <= chk_edges + DLY_W'(1);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_forced_nack_data: assert property ( // [R1]
    byte_taken && forced_refuse |=> ack_valid && !ack)
    else $error("Forced refuse did not give NACK");
  chk_role_other_ack: assert property ( // [R2]
    byte_taken && !rx_byte.slave_rx && !rx_byte.is_addr
    |=> ack == $past(rx_byte.normal_ack))
    else $error("Refuse bit affected a non slave receiver byte");
  // A pop in the same cycle may lower the level, but a refused byte never raises it
  chk_refused_not_pushed: assert property ( // [R3]
    byte_taken && forced_refuse |-> !fifo_push ##1 rx_level <= $past(rx_level))
    else $error("Refused byte entered the receive FIFO");
  chk_normal_ack_path: assert property ( // [R4]
    byte_taken && !refuse_nack && !rx_byte.is_addr
    |=> ack_valid && ack == $past(rx_byte.normal_ack))
    else $error("Normal acknowledge not followed");
  chk_rx_req_enable: assert property ( // [R5]
    rx_dma_req |-> $past(dma_enable[BIT_RX_DMA_EN]) && $past(rx_level) > LVL_W'($past(rx_wm)))
    else $error("Receive request without enable or level");
  chk_tx_req_enable: assert property ( // [R6]
    !dma_enable[BIT_TX_DMA_EN] |=> !tx_dma_req)
    else $error("Transmit request while disabled");
  chk_tx_level_req: assert property ( // [R8]
    dma_enable[BIT_TX_DMA_EN] && tx_fifo_level <= LVL_W'(tx_wm) |=> tx_dma_req)
    else $error("Transmit request missing at watermark");
  chk_rx_req_drop: assert property ( // [R9]
    rx_level <= LVL_W'(rx_wm) |=> !rx_dma_req)
    else $error("Receive request above level condition");
  chk_setup_count: assert property ( // [R14]
    scl_release |-> $past(chk_edges) + DLY_W'(1) >= chk_load)
    else $error("Clock released before setup count elapsed");
  chk_gc_ack_policy: assert property ( // [R11]
    byte_taken && rx_byte.is_addr && rx_byte.is_gc |=> ack == $past(gc_ack))
    else $error("General Call answer differs from control bit");

endmodule

// ### testbench/i2c_slave_ack_dma_handshake_tb.sv
// Purpose: Self-checking bench for the slave acknowledge and DMA request block
// Assumes: Register map and reset values of the shared package
// Notes:   Drivers queue expected results; monitors match them as outputs appear
`timescale 1ns/1ns

module i2c_slave_ack_dma_handshake_tb
  import iadh_pkg::*;
;
  localparam logic [7:0]  OFS_TAB [7] = '{8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h98, 8'ha0};
  localparam logic [31:0] RST_TAB [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h64, 32'h1, 32'h0};
  localparam logic [31:0] MSK_TAB [7] = '{32'h1, 32'h3, 32'h7, 32'h7, 32'h1ff, 32'h1, 32'h0};

  logic              clk, rst_n, i2c_reference_clock, rx_byte_valid, rx_byte_ready;
  logic              ack_valid, ack, setup_start, sda_hold, scl_release, tx_dma_req;
  logic              rx_dma_req, rx_dma_valid, rx_dma_ready, stall, ref_run, rd_d, taken;
  iadh_reg_req_s     reg_req;
  iadh_rx_byte_s     rx_byte;
  logic [31:0]       reg_rdata;
  logic [LVL_W-1:0]  tx_fifo_level;
  logic [BYTE_W-1:0] rx_dma_data;
  logic [7:0]        rnd, r;
  logic [31:0]       rdq[$];
  logic              ackq[$];
  logic [7:0]        dq[$];
  int                errors, checked, i, n;

  iadh_top dut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .i2c_reference_clock(i2c_reference_clock), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready), .ack_valid(ack_valid),
    .ack(ack), .setup_start(setup_start), .sda_hold(sda_hold), .scl_release(scl_release),
    .tx_fifo_level(tx_fifo_level), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req),
    .rx_dma_data(rx_dma_data), .rx_dma_valid(rx_dma_valid), .rx_dma_ready(rx_dma_ready));

  iadh_dma_model dma (.clk(clk), .rst_n(rst_n), .stall(stall), .ref_run(ref_run),
    .rx_dma_data(rx_dma_data), .rx_dma_valid(rx_dma_valid), .rx_dma_ready(rx_dma_ready),
    .i2c_reference_clock(i2c_reference_clock));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    rdq.push_back(exp);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
  endtask

  // Context is {is_addr, is_gc, slave_rx, normal_ack}; gives up after 40 cycles
  task automatic send(input logic [3:0] ctx, input logic exp_ack, input logic push);
    rnd = lfsr(rnd);
    @(posedge clk);
    rx_byte       <= {rnd, ctx};
    rx_byte_valid <= 1'b1;
    taken = 1'b0;
    for (n = 0; n < 40 && !taken; n++)
    begin
      @(posedge clk);
      taken = rx_byte_ready;
    end
    rx_byte_valid <= 1'b0;
    if (taken)
    begin
      ackq.push_back(exp_ack);
      if (push)
        dq.push_back(rnd);
    end
  endtask

  // Scoreboard: the oldest note is matched when each result appears
  always @(posedge clk)
  begin
    if (rd_d)
      check("reg_rdata", reg_rdata, rdq.pop_front());
    if (ack_valid)
      check("ack", 32'(ack), 32'(ackq.pop_front()));
    if (rx_dma_valid && rx_dma_ready)
      check("rx_dma_data", 32'(rx_dma_data), 32'(dq.pop_front()));
    rd_d <= reg_req.rd && rst_n;
  end

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end

  // Watchdog, well beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    {rst_n, rx_byte_valid, setup_start, stall, ref_run} = '0;
    reg_req = '0;
    rx_byte = '0;
    tx_fifo_level = '0;
    rnd = 8'h57;
    errors = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 7; i++)
      reg_rd(OFS_TAB[i], RST_TAB[i]);
    for (i = 0; i < 7; i++)
    begin
      reg_wr(OFS_TAB[i], 32'hffffffff);
      reg_rd(OFS_TAB[i], MSK_TAB[i]);
    end
    reg_wr(OFS_SLAVE_DATA_REFUSE, 32'h0);
    send(4'b1100, 1'b1, 1'b0);
    reg_wr(OFS_GC_ACK_CTRL, 32'h0);
    send(4'b1101, 1'b0, 1'b0);
    send(4'b0011, 1'b1, 1'b1);
    send(4'b0010, 1'b0, 1'b0);
    reg_wr(OFS_SLAVE_DATA_REFUSE, 32'h1);
    send(4'b0011, 1'b0, 1'b0);
    send(4'b0001, 1'b1, 1'b1);
    send(4'b0000, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    // Random enables, transmit watermarks and transmit levels around the threshold
    for (i = 0; i < 16; i++)
    begin
      r = lfsr(rnd);
      rnd = lfsr(r);
      reg_wr(OFS_DMA_REQ_ENABLE, {30'h0, r[7:6]});
      reg_wr(OFS_TX_DMA_WATERMARK, {29'h0, r[2:0]});
      tx_fifo_level <= {2'b00, rnd[3:0]};
      repeat (3) @(posedge clk);
      check("tx_dma_req", 32'(tx_dma_req), 32'(r[7] && rnd[3:0] <= r[2:0]));
      check("rx_dma_req", 32'(rx_dma_req), 32'h0);
    end
    // Fill the receive FIFO with the DMA stalled, then drain it
    stall <= 1'b1;
    reg_wr(OFS_SLAVE_DATA_REFUSE, 32'h0);
    reg_wr(OFS_RX_DMA_WATERMARK, 32'h3);
    reg_wr(OFS_DMA_REQ_ENABLE, 32'h1);
    for (i = 1; i <= 32; i++)
    begin
      send(4'b0011, 1'b1, 1'b1);
      repeat (3) @(posedge clk);
      check("rx_dma_req", 32'(rx_dma_req), 32'(i > 3));
    end
    send(4'b0011, 1'b1, 1'b1);
    check("taken_when_full", 32'(taken), 32'h0);
    reg_wr(OFS_DMA_REQ_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    check("rx_dma_req", 32'(rx_dma_req), 32'h0);
    stall <= 1'b0;
    for (n = 0; n < 200 && (rx_dma_valid !== 1'b0 || n < 3); n++)
      @(posedge clk);
    check("rx_dma_valid", 32'(rx_dma_valid), 32'h0);
    // Setup windows of 2 and 5 reference periods, 8 clock cycles each
    for (i = 2; i <= 5; i += 3)
    begin
      reg_wr(OFS_SDA_SETUP_DELAY, i); // Never below 2
      setup_start <= 1'b1;
      ref_run <= 1'b1;
      @(posedge clk);
      setup_start <= 1'b0;
      @(posedge clk);
      check("sda_hold", 32'(sda_hold), 32'h1);
      for (n = 0; n < 100 && scl_release !== 1'b1; n++)
        @(posedge clk);
      check("setup_len", 32'(n >= (i - 1) * 8 && n <= i * 8 + 6), 32'h1);
      check("sda_hold_end", 32'(sda_hold), 32'h0);
      ref_run <= 1'b0;
    end
    repeat (4) @(posedge clk);
    check("queues_left", rdq.size() + ackq.size() + dq.size(), 32'h0);
    stop_test();
  end
endmodule

// ### testbench/iadh_dma_model.sv
// Purpose: Far-side model: DMA controller draining receive bytes, reference clock source
// Assumes: Stall and clock-run controls come from the bench
// Notes:   Reference clock stands still low outside setup windows
`timescale 1ns/1ns

module iadh_dma_model
  import iadh_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              stall,
  input  wire logic              ref_run,
  input  wire logic [BYTE_W-1:0] rx_dma_data,
  input  wire logic              rx_dma_valid,
  output logic                   rx_dma_ready,
  output logic                   i2c_reference_clock
);
  logic [15:0] item;

  // Pops bytes unless stalled; a stall lags one cycle like a real arbiter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_dma_ready <= 1'b0;
      item         <= 16'h0000;
    end
    else
    begin
      rx_dma_ready <= !stall;
      if (rx_dma_valid && rx_dma_ready)
        item <= {item[7:0], rx_dma_data}; // Bytes paired into 16-bit items
    end
  end

  // 64 ns clock, held low between windows so no stray edges are counted
  initial
  begin
    i2c_reference_clock = 1'b0;
    forever
    begin
      #32;
      i2c_reference_clock = ref_run ? !i2c_reference_clock : 1'b0;
    end
  end
endmodule
